// File: hw/wws_pkg.sv
package wws_pkg;

    // ==========================================
    // Clock
    // ==========================================
    localparam int unsigned CLK_FREQ_HZ = 125_000_000;

    // ==========================================
    // Upper window limits, in microseconds
    // ==========================================
    localparam longint unsigned WIN_SHORT_US = 64'd250_000;
    localparam longint unsigned WIN_LONG_US  = 64'd2_500_000;
    // Capacitor mode: window = cap / 15.55 pF * 6.25 ms (cap in fF, times in ns)
    localparam longint unsigned CAP_UNIT_FF  = 64'd15_550;
    localparam longint unsigned CAP_STEP_NS  = 64'd6_250_000;
    localparam longint unsigned CAP_DEF_FF   = 64'd1_555_000;
    localparam longint unsigned CAP_MIN_FF   = 64'd155_000;
    localparam longint unsigned CAP_MAX_FF   = 64'd63_000_000;

    // ==========================================
    // Ratio denominators, times ten
    // ==========================================
    localparam longint unsigned RAT_S_LO_X10 = 64'd318;
    localparam longint unsigned RAT_S_HI_X10 = 64'd1249;
    localparam longint unsigned RAT_L_LO_X10 = 64'd320;
    localparam longint unsigned RAT_L_HI_X10 = 64'd1277;
    localparam longint unsigned RAT_C_LO_X10 = 64'd258;
    localparam longint unsigned RAT_C_HI_X10 = 64'd645;

    // ==========================================
    // Lower boundaries for fixed settings, in nanoseconds
    // ==========================================
    localparam longint unsigned LB_S_LO_NS = 64'd7_860_000;
    localparam longint unsigned LB_S_HI_NS = 64'd2_000_000;
    localparam longint unsigned LB_L_LO_NS = 64'd78_200_000;
    localparam longint unsigned LB_L_HI_NS = 64'd19_600_000;

    localparam int CNT_W = 32;

    // Any time rounds down to whole cycles; less than one cycle gives one
    function automatic longint unsigned wws_ns2cyc(input longint unsigned ns);
        longint unsigned c;
        c = (ns * CLK_FREQ_HZ) / 64'd1_000_000_000;
        return (c < 64'd1) ? 64'd1 : c;
    endfunction

    typedef enum logic [1:0]
    {
        WWS_ON    = 2'b01,
        WWS_RESET = 2'b10
    } wws_state_type;

    typedef enum logic [2:0]
    {
        WWS_SEL_SHORT = 3'b001,
        WWS_SEL_LONG  = 3'b010,
        WWS_SEL_CAP   = 3'b100
    } wws_sel_type;

endpackage

// File: hw/wws_edge_sync.sv
`timescale 1ns/10ps

// ==========================================
// Two-stage sampler with rising-edge pulse
// ==========================================
module wws_edge_sync
(
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic din,
    output logic      rise
);

    logic meta_ff;
    logic sync_ff;
    logic prev_ff;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            prev_ff <= 1'b0;
        end
        else
        begin
            meta_ff <= din;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    assign rise = sync_ff & ~prev_ff;

endmodule // wws_edge_sync

// File: hw/window_watchdog_supervisor.sv
`timescale 1ns/10ps

// Functional notes
// - First window after reset release has no early-trigger check.
// - After first detected trigger edge, early check applies to every later window.
// - Each trigger edge clears the window timer and starts a new window.
// - Timeout or early trigger is a fault and asserts reset.
// - Two states: on with output high, reset with output low.
// - Timeout strap low 0.25 s, high 2.5 s, else capacitor timing.
// - Ratio strap high: denominators 124.9, 127.7, 64.5.
// - Ratio strap low: denominators 31.8, 32, 25.8.
// - Fixed lower boundaries 7.86 ms, 2 ms, 78.2 ms, 19.6 ms.
// - Trigger is sampled on the internal clock; edge acts two cycles after its first sample.
// - Capacitor window equals cap / 15.55 pF times 6.25 ms.

module window_watchdog_supervisor
#(
    parameter longint unsigned CAP_FF        = wws_pkg::CAP_DEF_FF,
    // Cycles spent in the reset state after a fault; the reset output stays low one cycle longer
    parameter int unsigned     FAULT_HOLD    = 16,
    // Test hook: nonzero overrides every upper window, in cycles
    parameter longint unsigned WIN_OVR_CYC   = 0
)
(
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic watchdog_trigger_in,
    input  wire logic timeout_select_strap,
    input  wire logic timeout_select_float,
    input  wire logic window_ratio_strap,
    input  wire logic supply_above_threshold,
    output logic      resetOut_n,
    output logic      faultTimeout,
    output logic      faultEarly
);

    // ==========================================
    // Window limits
    // ==========================================
    localparam longint unsigned WIN_S_CYC =
        wws_pkg::wws_ns2cyc(wws_pkg::WIN_SHORT_US * 64'd1000);
    localparam longint unsigned WIN_L_CYC =
        wws_pkg::wws_ns2cyc(wws_pkg::WIN_LONG_US * 64'd1000);
    localparam longint unsigned WIN_C_CYC = wws_pkg::wws_ns2cyc(
        (CAP_FF * wws_pkg::CAP_STEP_NS) / wws_pkg::CAP_UNIT_FF);
    localparam longint unsigned LB_S_LO = wws_pkg::wws_ns2cyc(wws_pkg::LB_S_LO_NS);
    localparam longint unsigned LB_S_HI = wws_pkg::wws_ns2cyc(wws_pkg::LB_S_HI_NS);
    localparam longint unsigned LB_L_LO = wws_pkg::wws_ns2cyc(wws_pkg::LB_L_LO_NS);
    localparam longint unsigned LB_L_HI = wws_pkg::wws_ns2cyc(wws_pkg::LB_L_HI_NS);
    localparam longint unsigned LB_C_LO =
        wws_pkg::wws_ns2cyc((WIN_C_CYC * 64'd80) / wws_pkg::RAT_C_LO_X10);
    localparam longint unsigned LB_C_HI =
        wws_pkg::wws_ns2cyc((WIN_C_CYC * 64'd80) / wws_pkg::RAT_C_HI_X10);

    // ==========================================
    // Parameter checks
    // ==========================================
    // Refused at elaboration, so a bad build never reaches simulation or silicon
    if (CAP_FF < wws_pkg::CAP_MIN_FF || CAP_FF > wws_pkg::CAP_MAX_FF)
    begin : g_capRange
        $error("Capacitance out of range");
    end
    if (FAULT_HOLD < 1)
    begin : g_holdMin
        $error("FAULT_HOLD must be at least one");
    end
    // A window longer than the counter would wrap and never time out
    if (WIN_C_CYC >= (64'd1 << wws_pkg::CNT_W) || WIN_OVR_CYC >= (64'd1 << wws_pkg::CNT_W))
    begin : g_cntWidth
        $error("Window does not fit the window counter");
    end

    logic [wws_pkg::CNT_W-1:0] winMax;
    logic [wws_pkg::CNT_W-1:0] lbMin;
    wws_pkg::wws_sel_type      sel;

    always_comb
    begin
        if (timeout_select_float)
            sel = wws_pkg::WWS_SEL_CAP;
        else if (timeout_select_strap)
            sel = wws_pkg::WWS_SEL_LONG;
        else
            sel = wws_pkg::WWS_SEL_SHORT;
    end

    always_comb
    begin
        case (sel)
            wws_pkg::WWS_SEL_LONG:
            begin
                winMax = wws_pkg::CNT_W'(WIN_L_CYC);
                lbMin  = window_ratio_strap ? wws_pkg::CNT_W'(LB_L_HI)
                                            : wws_pkg::CNT_W'(LB_L_LO);
            end
            wws_pkg::WWS_SEL_CAP:
            begin
                winMax = wws_pkg::CNT_W'(WIN_C_CYC);
                lbMin  = window_ratio_strap ? wws_pkg::CNT_W'(LB_C_HI)
                                            : wws_pkg::CNT_W'(LB_C_LO);
            end
            default:
            begin
                winMax = wws_pkg::CNT_W'(WIN_S_CYC);
                lbMin  = window_ratio_strap ? wws_pkg::CNT_W'(LB_S_HI)
                                            : wws_pkg::CNT_W'(LB_S_LO);
            end
        endcase
        if (WIN_OVR_CYC != 0)
        begin
            winMax = wws_pkg::CNT_W'(WIN_OVR_CYC);
            lbMin  = wws_pkg::CNT_W'(WIN_OVR_CYC / 64'd8);
        end
    end

    // ==========================================
    // Trigger sampling
    // ==========================================
    logic trigRise;

    wws_edge_sync u_trig
    (
        .clk  (clk),
        .rstn (rstn),
        .din  (watchdog_trigger_in),
        .rise (trigRise)
    );

    // ==========================================
    // State
    // ==========================================
    wws_pkg::wws_state_type    state_ff;
    logic [wws_pkg::CNT_W-1:0] winCnt_ff;
    logic [wws_pkg::CNT_W-1:0] holdCnt_ff;
    logic                      lbEnable_ff;
    logic                      timeoutHit;
    logic                      earlyHit;
    logic                      holdDone;

    assign timeoutHit = (state_ff == wws_pkg::WWS_ON) && !trigRise
                        && (winCnt_ff >= winMax - 1'b1);
    assign earlyHit   = (state_ff == wws_pkg::WWS_ON) && trigRise
                        && lbEnable_ff && (winCnt_ff < lbMin);
    assign holdDone   = holdCnt_ff >= wws_pkg::CNT_W'(FAULT_HOLD - 1);

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            state_ff <= wws_pkg::WWS_RESET;
        else
        begin
            case (state_ff)
                wws_pkg::WWS_ON:
                    if (!supply_above_threshold || timeoutHit || earlyHit)
                        state_ff <= wws_pkg::WWS_RESET;
                wws_pkg::WWS_RESET:
                    if (supply_above_threshold && holdDone)
                        state_ff <= wws_pkg::WWS_ON;
                default:
                    state_ff <= wws_pkg::WWS_RESET;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            holdCnt_ff <= '0;
        else if (state_ff == wws_pkg::WWS_ON)
            holdCnt_ff <= '0;
        else if (!holdDone)
            holdCnt_ff <= holdCnt_ff + 1'b1;
    end

    // Window timer restarts on every trigger edge and while in reset
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            winCnt_ff <= '0;
        else if (state_ff != wws_pkg::WWS_ON || trigRise)
            winCnt_ff <= '0;
        else
            winCnt_ff <= winCnt_ff + 1'b1;
    end

    // Early check armed only once the first edge has been seen
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            lbEnable_ff <= 1'b0;
        else if (state_ff != wws_pkg::WWS_ON)
            lbEnable_ff <= 1'b0;
        else if (trigRise)
            lbEnable_ff <= 1'b1;
    end

    // ==========================================
    // Outputs
    // ==========================================
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            resetOut_n   <= 1'b0;
            faultTimeout <= 1'b0;
            faultEarly   <= 1'b0;
        end
        else
        begin
            resetOut_n   <= (state_ff == wws_pkg::WWS_ON) && supply_above_threshold
                            && !timeoutHit && !earlyHit;
            faultTimeout <= timeoutHit;
            faultEarly   <= earlyHit;
        end
    end

endmodule // window_watchdog_supervisor

// File: dv/wws_checker_props.sv
`timescale 1ns/10ps

// ==========================================
// Port checker
// ==========================================
module wws_checker
#(
    parameter longint unsigned WIN_OVR_CYC = 0
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic watchdog_trigger_in,
    input wire logic supply_above_threshold,
    input wire logic resetOut_n,
    input wire logic faultTimeout,
    input wire logic faultEarly
);
    localparam longint WIN_LO = (WIN_OVR_CYC > 4) ? WIN_OVR_CYC - 4 : 0;
    localparam longint WIN_HI = WIN_OVR_CYC + 6;
    logic [31:0] quietCnt_ff;

    // Counts from the pin edge, so it runs a few cycles ahead of the synced view
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            quietCnt_ff <= '0;
        else if (!resetOut_n || $rose(watchdog_trigger_in))
            quietCnt_ff <= '0;
        else
            quietCnt_ff <= quietCnt_ff + 32'h1;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    chk_supply_forces_rst: assert property (!supply_above_threshold |-> ##[1:2] !resetOut_n)
        else $error("reset output high with supply low");
    chk_fault_asserts_rst: assert property ((faultTimeout || faultEarly) |-> ##[0:1] !resetOut_n)
        else $error("fault without reset output");
    chk_rst_min_hold: assert property ($fell(resetOut_n) |-> !resetOut_n [*8])
        else $error("reset output pulse too short");
    chk_fault_kinds_apart: assert property (!(faultTimeout && faultEarly))
        else $error("both fault kinds at once");
    chk_timeout_single: assert property (faultTimeout |=> !faultTimeout)
        else $error("timeout fault longer than one cycle");
    chk_early_needs_edge: assert property (faultEarly |-> $past(watchdog_trigger_in, 3))
        else $error("early fault without trigger edge");
    chk_early_only_on: assert property (faultEarly |-> $past(resetOut_n))
        else $error("early fault while in reset");
    chk_timeout_not_soon: assert property (faultTimeout |-> quietCnt_ff >= WIN_LO)
        else $error("timeout before window end");
    chk_window_upper: assert property ((WIN_OVR_CYC != 0) |-> quietCnt_ff <= WIN_HI)
        else $error("no timeout after window end");
endmodule // wws_checker

bind window_watchdog_supervisor wws_checker #(.WIN_OVR_CYC(WIN_OVR_CYC)) chk
(
    .clk                    (clk),
    .rstn                   (rstn),
    .watchdog_trigger_in    (watchdog_trigger_in),
    .supply_above_threshold (supply_above_threshold),
    .resetOut_n             (resetOut_n),
    .faultTimeout           (faultTimeout),
    .faultEarly             (faultEarly)
);

// File: dv/wws_trig_host.sv
`timescale 1ns/10ps

// ==========================================
// Servicing processor trigger model
// ==========================================
module wws_trig_host
(
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic fire,
    output logic      watchdog_trigger_in
);
    logic [3:0] hold_ff;

    // Eight cycles is 64 ns, safely above the minimum pulse width
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            hold_ff <= '0;
        else if (fire)
            hold_ff <= 4'h8;
        else if (hold_ff != '0)
            hold_ff <= hold_ff - 4'h1;
    end

    assign watchdog_trigger_in = (hold_ff != '0);
endmodule // wws_trig_host

// File: dv/tb_window_watchdog_supervisor.sv
`timescale 1ns/10ps

module tb_window_watchdog_supervisor;
    logic clk, rstn, fire, trig, tStrap, tFloat, rStrap, supplyOk;
    logic resetOut_n, faultTimeout, faultEarly;
    int   num_errors, comparisons, nEarly, nTout, i;

    always #4 clk = ~clk;
    always @(posedge clk) if (faultEarly === 1'b1) nEarly++;
    always @(posedge clk) if (faultTimeout === 1'b1) nTout++;

    // Short window keeps the run brief; lower boundary is 50 cycles
    window_watchdog_supervisor
    #(
        .CAP_FF      (wws_pkg::CAP_MIN_FF),
        .WIN_OVR_CYC (400)
    ) DUT
    (
        .clk                    (clk),
        .rstn                   (rstn),
        .watchdog_trigger_in    (trig),
        .timeout_select_strap   (tStrap),
        .timeout_select_float   (tFloat),
        .window_ratio_strap     (rStrap),
        .supply_above_threshold (supplyOk),
        .resetOut_n             (resetOut_n),
        .faultTimeout           (faultTimeout),
        .faultEarly             (faultEarly)
    );

    wws_trig_host host (.clk(clk), .rstn(rstn), .fire(fire), .watchdog_trigger_in(trig));

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic pulse(input int gap);
        repeat (gap) @(posedge clk);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
    endtask

    task automatic wait_up();
        for (i = 0; i < 100 && resetOut_n !== 1'b1; i++)
            @(posedge clk);
        check(32'(resetOut_n), 32'h1);
        if (resetOut_n !== 1'b1)
            complete_run();
    endtask

    task automatic test_windows();
        wait_up();
        pulse(10);
        repeat (20) @(posedge clk);
        check(nEarly, 32'h0);
        pulse(150);
        repeat (6) @(posedge clk);
        check(nEarly, 32'h0);
        check(32'(resetOut_n), 32'h1);
        pulse(20);
        repeat (6) @(posedge clk);
        check(nEarly, 32'h1);
        check(32'(resetOut_n), 32'h0);
        $display("windows done");
    endtask

    task automatic test_restart_modes();
        wait_up();
        pulse(5);
        for (int m = 0; m < 6; m++)
        begin
            tFloat <= (m > 3);
            tStrap <= m[0];
            rStrap <= m[1];
            pulse(120 + 40 * m);
        end
        check(nEarly, 32'h1);
        check(nTout, 32'h0);
        $display("restart done");
    endtask

    task automatic test_timeout();
        for (i = 0; i < 600 && nTout == 0; i++)
            @(posedge clk);
        check(32'(i >= 398 && i <= 412), 32'h1);
        check(32'(resetOut_n), 32'h0);
        $display("timeout done");
    endtask

    task automatic test_supply();
        wait_up();
        supplyOk <= 1'b0;
        repeat (40) @(posedge clk);
        check(32'(resetOut_n), 32'h0);
        supplyOk <= 1'b1;
        wait_up();
        check(nEarly + nTout, 32'h2);
        $display("supply done");
    endtask

    initial
    begin
        clk = 1'b0;
        rstn <= 1'b0;
        fire <= 1'b0;
        tStrap <= 1'b0;
        tFloat <= 1'b0;
        rStrap <= 1'b0;
        supplyOk <= 1'b1;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        test_windows();
        test_restart_modes();
        test_timeout();
        test_supply();
        complete_run();
    end
endmodule // tb_window_watchdog_supervisor
